//--- shared/pt_params.svh
// constants for the prescaled 16-bit count block
//
// Summary of operation
// - The block holds a 16-bit count that software can read and write as two bytes.
// - The upper eight count bits form one byte register and the lower eight form another.
// - An 8-bit software-programmable prescaler sits ahead of the count, giving up to 24 bits of range.
// - Software chooses whether the count runs from the instruction-cycle clock or the input pin.
// - Source-select bit 5 at one picks the instruction cycle, at zero picks the pin.
// - With the pin selected and edge-select bit 6 at one, rising pin edges count and set the edge flag.
// - Edge-select chooses the pin edge that counts and sets the edge flag; with the internal source in use it still picks the flag edge.
// - Prescale bits 4-1 give 1:1 doubling up to 1:128 for codes 0000-0111, and 1:256 for any 1xxx.
// - The control register decodes at data address 05h regardless of bank selection.
// - With the pin selected and edge-select at zero, falling pin edges count and set the edge flag.
// - Overflow of the 16-bit count raises the overflow flag.
`ifndef PT_PARAMS_SVH
`define PT_PARAMS_SVH

// ==========================================
// addresses
`define PT_ADDR_CONTROL   8'h05
`define PT_ADDR_COUNT_LO  8'h0b
`define PT_ADDR_COUNT_HI  8'h0c

// ==========================================
// control register fields and reset
`define PT_BIT_EXT_IRQ_EDGE 7
`define PT_BIT_EDGE_SEL     6
`define PT_BIT_SRC_SEL      5
`define PT_PS_MSB           4
`define PT_PS_LSB           1
`define PT_CONTROL_RESET    8'h00
`define PT_CONTROL_WMASK    8'hfe
`define PT_COUNT_RESET      16'h0000

// ==========================================
// timing
`define PT_CLK_PERIOD_NS    10

`endif

//--- shared/pt_pkg.sv
// types shared by the prescaled 16-bit count block
package pt_pkg;

	// data-bus access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pt_bus_s;

	// count source
	typedef enum logic [0:0] {
		PT_SRC_PIN  = 1'b0,
		PT_SRC_CYCLE = 1'b1
	} pt_src_e;

endpackage : pt_pkg

//--- design/pt_timer.sv
// prescaled 16-bit timer/counter with its control and count registers
`timescale 1ns/10ps
`include "pt_params.svh"

module pt_timer #(
	parameter int PS_BITS = 8
) (
	// clock and reset
	input  wire logic           clk_sys,
	input  wire logic           rst_n,
	// register access
	input  wire pt_pkg::pt_bus_s bus,
	output      logic [7:0]     rdata,
	// external count pin
	input  wire logic           count_input_pin,
	// events and status
	output      logic           external_edge_flag,
	output      logic           overflow_flag,
	output      logic           ext_irq_edge_select
);

	// ==========================================
	// elaboration check
	if (PS_BITS != 8) begin : g_bad_ps
		$error("prescaler must be eight bits wide");
	end

	// ==========================================
	// state
	logic [7:0]         count_control;
	logic [15:0]        main_count;
	logic [PS_BITS-1:0] prescaler;
	logic               pin_s1;
	logic               pin_s2;
	logic               pin_s3;

	// ==========================================
	// decode
	wire logic       sel_ctrl = bus.addr == `PT_ADDR_CONTROL;
	wire logic       sel_lo   = bus.addr == `PT_ADDR_COUNT_LO;
	wire logic       sel_hi   = bus.addr == `PT_ADDR_COUNT_HI;
	wire logic       wr_ctrl  = bus.wr && sel_ctrl;
	wire logic       wr_lo    = bus.wr && sel_lo;
	wire logic       wr_hi    = bus.wr && sel_hi;
	wire pt_pkg::pt_src_e src = pt_pkg::pt_src_e'(count_control[`PT_BIT_SRC_SEL]);
	wire logic       edge_sel = count_control[`PT_BIT_EDGE_SEL];
	wire logic [3:0] ps_code  = count_control[`PT_PS_MSB:`PT_PS_LSB];

	// edge detection looks only at the second and third stages
	wire logic rise     = pin_s2 && !pin_s3;
	wire logic fall     = !pin_s2 && pin_s3;
	wire logic pin_edge = edge_sel ? rise : fall;

	// source picks the tick; edge select is ignored on the cycle clock
	wire logic tick = (src == pt_pkg::PT_SRC_CYCLE) ? 1'b1 : pin_edge;

	// divide ratio 2^code, any code with top bit set gives 256
	function automatic logic [PS_BITS-1:0] ps_limit(input logic [3:0] code);
		logic [8:0] full;
		full = 9'h001 << (code[3] ? 4'h8 : {1'b0, code[2:0]});
		ps_limit = PS_BITS'(full - 9'h001);
	endfunction : ps_limit

	wire logic [PS_BITS-1:0] limit   = ps_limit(ps_code);
	wire logic               ps_out  = tick && (prescaler >= limit);
	wire logic [16:0]        sum     = {1'b0, main_count} + 17'h00001;
	wire logic               ovf     = ps_out && sum[16];

	wire logic [7:0] next_rdata = sel_ctrl ? {count_control[7:1], 1'b0} :
	                              sel_lo   ? main_count[7:0] :
	                              sel_hi   ? main_count[15:8] : 8'h00;

	// ==========================================
	// pin synchroniser
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
		end else begin
			pin_s1 <= count_input_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// ==========================================
	// control register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			count_control <= `PT_CONTROL_RESET;
		end else if (wr_ctrl) begin
			count_control <= bus.wdata & `PT_CONTROL_WMASK;
		end
	end

	// ==========================================
	// prescaler; a control write restarts it so the new ratio takes clean effect
	always_ff @(posedge clk_sys) begin
		if (!rst_n || wr_ctrl) begin
			prescaler <= '0;
		end else if (ps_out) begin
			prescaler <= '0;
		end else if (tick) begin
			prescaler <= prescaler + PS_BITS'(1);
		end
	end

	// ==========================================
	// count; a byte write wins over a tick in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			main_count <= `PT_COUNT_RESET;
		end else if (wr_lo) begin
			main_count[7:0] <= bus.wdata;
		end else if (wr_hi) begin
			main_count[15:8] <= bus.wdata;
		end else if (ps_out) begin
			main_count <= sum[15:0];
		end
	end

	// ==========================================
	// outputs: registered read data, the irq edge level and one-cycle event pulses, flag storage lives in the core
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata               <= 8'h00;
			external_edge_flag  <= 1'b0;
			overflow_flag       <= 1'b0;
			ext_irq_edge_select <= 1'b0;
		end else begin
			rdata               <= bus.rd ? next_rdata : 8'h00;
			external_edge_flag  <= pin_edge;
			overflow_flag       <= ovf && !(wr_lo || wr_hi);
			ext_irq_edge_select <= count_control[`PT_BIT_EXT_IRQ_EDGE];
		end
	end

	// ==========================================
	// checks
	sequence s_full_count;
		ps_out && main_count == 16'hffff && !bus.wr;
	endsequence

	AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_full_count |=> main_count == 16'h0000)
		else $error("count did not wrap to zero");
	AST_OVF: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_full_count |=> overflow_flag)
		else $error("overflow flag missing on wrap");
	AST_INC: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ps_out && !bus.wr |=> main_count == $past(main_count) + 16'h0001)
		else $error("count did not step by one");
	AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ps_out && !bus.wr |=> main_count == $past(main_count))
		else $error("count moved without a prescaler pulse");
	AST_CYCLE_1TO1: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src == pt_pkg::PT_SRC_CYCLE && ps_code == 4'h0 && !wr_lo && !wr_hi
			|=> main_count == $past(main_count) + 16'h0001)
		else $error("cycle clock at 1:1 must step the count every cycle");
	AST_RATIO_256: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ps_code[3] |-> limit == 8'hff)
		else $error("top prescale codes must divide by 256");
	AST_PIN_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src == pt_pkg::PT_SRC_PIN && !pin_edge |-> !ps_out)
		else $error("pin source counted without an edge");
	AST_EDGE_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!edge_sel && fall |=> external_edge_flag)
		else $error("falling edge did not raise the edge flag");
	AST_CTRL_RD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus.rd && sel_ctrl |=> rdata[0] == 1'b0 && rdata[7:1] == $past(count_control[7:1]))
		else $error("control read wrong");

	// ==========================================
	// ratio reference: the prescale table written out, kept apart from ps_limit
	// so that a slip in the shift arithmetic cannot hide behind itself
	function automatic logic [8:0] ratio_of(input logic [3:0] code);
		case (code)
			4'h0: ratio_of = 9'h001;
			4'h1: ratio_of = 9'h002;
			4'h2: ratio_of = 9'h004;
			4'h3: ratio_of = 9'h008;
			4'h4: ratio_of = 9'h010;
			4'h5: ratio_of = 9'h020;
			4'h6: ratio_of = 9'h040;
			4'h7: ratio_of = 9'h080;
			default: ratio_of = 9'h100;
		endcase
	endfunction : ratio_of

	logic [8:0]       chk_ticks;
	wire  logic [8:0] chk_next = chk_ticks + 9'h001;

	// ticks seen since the last prescaler pulse or control write
	always_ff @(posedge clk_sys) begin
		if (!rst_n || wr_ctrl || ps_out) begin
			chk_ticks <= 9'h000;
		end else if (tick) begin
			chk_ticks <= chk_next;
		end
	end

	sequence s_pin_rise;
		src == pt_pkg::PT_SRC_PIN && edge_sel && rise && ps_code == 4'h0
			&& !wr_lo && !wr_hi;
	endsequence

	AST_RATIO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tick && !wr_ctrl |-> ps_out == (chk_next == ratio_of(ps_code)))
		else $error("prescaler pulse does not match the selected ratio");
	AST_RISE_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		edge_sel && rise |=> external_edge_flag)
		else $error("rising edge did not raise the edge flag");
	AST_QUIET_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!pin_edge |=> !external_edge_flag)
		else $error("edge flag raised without a selected pin edge");
	AST_RISE_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_pin_rise |=> main_count == $past(main_count) + 16'h0001)
		else $error("rising pin edge did not step the count");
	AST_LO_WR: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_lo |=> main_count[7:0] == $past(bus.wdata) && main_count[15:8] == $past(main_count[15:8]))
		else $error("low byte write wrong");
	AST_HI_WR: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_hi |=> main_count[15:8] == $past(bus.wdata) && main_count[7:0] == $past(main_count[7:0]))
		else $error("high byte write wrong");
	AST_LO_RD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus.rd && sel_lo |=> rdata == $past(main_count[7:0]))
		else $error("low byte read wrong");
	AST_HI_RD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bus.rd && sel_hi |=> rdata == $past(main_count[15:8]))
		else $error("high byte read wrong");
	AST_IRQ_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> ext_irq_edge_select == $past(count_control[`PT_BIT_EXT_IRQ_EDGE]))
		else $error("interrupt edge select does not follow the control register");

endmodule : pt_timer

//--- testbench/pt_pin_src.sv
// external pulse source that drives the count input pin
`timescale 1ns/10ps

module pt_pin_src (
	// clock and control
	input  wire logic clk_sys,
	input  wire logic run,
	// driven pin
	output      logic count_input_pin
);
	logic [1:0] div   = 2'h0;
	logic       level = 1'b0;

	assign count_input_pin = level;

	// ==========================================
	// pin holds each level four cycles, four times the one-cycle minimum the sampler needs
	always @(posedge clk_sys) begin
		div <= div + 2'h1;
		if (run && div == 2'h3) begin
			level <= #1 ~level;
		end
	end
endmodule : pt_pin_src

//--- testbench/tb.sv
// self-checking bench for the prescaled 16-bit timer
`timescale 1ns/10ps

module tb;
	logic            clk_sys = 1'b0, rst_n = 1'b0, run = 1'b0, pin_q = 1'b0;
	logic            pin, ef, of, eis;
	logic [7:0]      rdata, v, lo;
	pt_pkg::pt_bus_s bus = '0;
	int              n_mismatch = 0, samples_checked = 0, r;
	int              n_rise = 0, n_fall = 0, n_flag = 0, n_ovf = 0;
	logic [3:0]      codes [4] = '{4'h0, 4'h3, 4'h7, 4'h9};

	always #5 clk_sys = ~clk_sys;

	pt_timer pt_timer_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.count_input_pin(pin), .external_edge_flag(ef), .overflow_flag(of),
		.ext_irq_edge_select(eis));
	pt_pin_src pt_pin_src_inst (.clk_sys(clk_sys), .run(run), .count_input_pin(pin));

	always @(posedge clk_sys) begin
		pin_q <= pin;
		n_rise += int'(pin & ~pin_q);
		n_fall += int'(~pin & pin_q);
		n_flag += int'(ef);
		n_ovf += int'(of);
	end

	// ==========================================
	// shared tasks; idle, wr and rd each return 1 ns after a rising edge
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus.addr = a;
		bus.wdata = d;
		bus.wr = 1'b1;
		idle(1);
		bus.wr = 1'b0;
		idle(1);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		bus.addr = a;
		bus.rd = 1'b1;
		idle(1);
		bus.rd = 1'b0;
		d = rdata;
		idle(1);
	endtask : rd

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// ==========================================
	// tests
	initial begin
		idle(4);
		rst_n = 1'b1;
		check("flags_reset", 16'({ef, of, eis}), 16'h0000);
		rd(8'h05, v);
		check("control_reset", 16'(v), 16'h00);
		rd(8'h0b, v);
		check("count_lo_reset", 16'(v), 16'h00);
		check("rdata_idle", 16'(rdata), 16'h00);
		wr(8'h05, 8'hff);
		rd(8'h05, v);
		check("control_rb", 16'(v), 16'hfe);
		check("irq_edge", 16'(eis), 16'h1);
		wr(8'h06, 8'h5a);
		rd(8'h06, v);
		check("unmapped", 16'(v), 16'h00);
		wr(8'h05, 8'h00);
		check("irq_edge_clr", 16'(eis), 16'h0);
		wr(8'h0b, 8'hfd);
		wr(8'h0c, 8'hff);
		rd(8'h0c, v);
		check("count_hi", 16'(v), 16'hff);
		n_ovf = 0;
		// cycle clock at 1:1 with edge select set, which must not matter; ten ticks
		wr(8'h05, 8'h60);
		idle(8);
		wr(8'h05, 8'h00);
		check("overflow", 16'(n_ovf), 16'h1);
		rd(8'h0b, v);
		check("wrap_lo", 16'(v), 16'h07);
		rd(8'h0c, v);
		check("wrap_hi", 16'(v), 16'h00);
		// the closing control write still ticks, so each window holds 1025 ticks
		foreach (codes[i]) begin
			r = codes[i][3] ? 256 : (1 << codes[i]);
			wr(8'h0b, 8'h00);
			wr(8'h0c, 8'h00);
			wr(8'h05, 8'h20 | {3'h0, codes[i], 1'b0});
			idle(1023);
			wr(8'h05, 8'h00);
			rd(8'h0b, lo);
			rd(8'h0c, v);
			check("prescale", {v, lo}, 16'(1025 / r));
		end
		for (int e = 1; e >= 0; e--) begin
			wr(8'h0b, 8'h00);
			wr(8'h0c, 8'h00);
			wr(8'h05, e ? 8'h40 : 8'h00);
			n_rise = 0;
			n_fall = 0;
			n_flag = 0;
			run = 1'b1;
			idle(40);
			run = 1'b0;
			idle(6);
			rd(8'h0b, v);
			check("pin_edges", 16'(n_rise + n_fall), 16'h000a);
			check("pin_count", 16'(v), 16'(e ? n_rise : n_fall));
			check("edge_flags", 16'(n_flag), 16'(e ? n_rise : n_fall));
		end
		stop_test();
	end

	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end
endmodule : tb
